/* File: fci_pkg.sv */
/*
 * Constants, field layouts and carrier types for the host-side controller
 * of a parallel boot-block flash. Assumes a 100 MHz clock and an APB
 * master reaching the controller's own registers.
 */
package fci_pkg;

    localparam int unsigned CLK_MHZ       = 100;
    localparam int unsigned ADDR_W        = 20;
    localparam int unsigned DATA_W        = 16;
    localparam int unsigned SYNC_STAGES   = 2;

    // bus timing in ns, converted to whole cycles rounding up
    localparam int unsigned T_SETUP_NS    = 20;
    localparam int unsigned T_STROBE_NS   = 60;
    localparam int unsigned T_ACCESS_NS   = 90;
    localparam int unsigned T_RECOVER_NS  = 30;
    localparam int unsigned T_SETUP_CYC   = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned T_STROBE_CYC  = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned T_ACCESS_CYC  = (T_ACCESS_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES;
    localparam int unsigned T_RECOVER_CYC = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;

    // flash command codes
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
    localparam logic [7:0] CMD_READ_ID      = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
    localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
    localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
    localparam logic [7:0] CMD_PROG_ALT     = 8'h10;
    localparam logic [7:0] CMD_SUSPEND      = 8'hb0;

    // operation codes in the control register
    localparam logic [3:0] OP_READ_ARRAY   = 4'h0;
    localparam logic [3:0] OP_READ_ID      = 4'h1;
    localparam logic [3:0] OP_READ_STATUS  = 4'h2;
    localparam logic [3:0] OP_CLEAR_STATUS = 4'h3;
    localparam logic [3:0] OP_ERASE        = 4'h4;
    localparam logic [3:0] OP_PROGRAM      = 4'h5;
    localparam logic [3:0] OP_SUSPEND      = 4'h6;
    localparam logic [3:0] OP_RESUME       = 4'h7;
    localparam logic [3:0] OP_READ         = 4'h8;
    localparam logic [3:0] OP_PROGRAM_ALT  = 4'h9;

    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    localparam logic [7:0] REG_PINS   = 8'h14;

    // status register fields
    localparam int unsigned ST_BUSY     = 0;
    localparam int unsigned ST_RB_READY = 1;
    localparam int unsigned ST_OP_ERR   = 2;
    localparam int unsigned ST_DONE     = 3;

    // pin control fields
    localparam int unsigned PIN_WP      = 0;
    localparam int unsigned PIN_RP      = 1;
    localparam int unsigned PIN_RP_HV   = 2;
    localparam logic [2:0]  PINS_RESET  = 3'h2;

    typedef struct packed {
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic              write_protect_n;
        logic              reset_powerdown_n;
        logic              rp_high_voltage_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic              dq_oe;
    } fci_pins_t;

    typedef struct packed {
        logic       valid;
        logic       rd;
        logic       use_wdata;
        logic [7:0] code;
    } fci_cyc_t;

endpackage : fci_pkg

/* File: fci_host_ctrl.sv */
/*
 * Host-side controller for a parallel boot-block flash: software starts
 * command sequences through APB registers, the controller plays them out
 * as chip-enable / output-enable / write-enable bus cycles.
 * Assumes dq_in and ready_busy_in arrive asynchronously from the pins and
 * that the board pulls the open-drain ready/busy line high.
 */
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module fci_host_ctrl
    import fci_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    output fci_pins_t              pins,
    input  wire logic [DATA_W-1:0] dq_in,
    input  wire logic              ready_busy_in
);

    typedef enum logic [1:0] {S_IDLE, S_SETUP, S_STROBE, S_RECOVER} fci_state_t;

    // one bus cycle of each operation; an invalid step ends the sequence
    function automatic fci_cyc_t op_step(input logic [3:0] op, input logic idx);
        fci_cyc_t c;
        c = '0;
        case (op)
            OP_READ_ARRAY:   c = idx ? '0 : fci_cyc_t'{1'b1, 1'b0, 1'b0, CMD_READ_ARRAY};
            OP_READ_ID:      c = idx ? fci_cyc_t'{1'b1, 1'b1, 1'b0, 8'h00}
                                     : fci_cyc_t'{1'b1, 1'b0, 1'b0, CMD_READ_ID};
            OP_READ_STATUS:  c = idx ? fci_cyc_t'{1'b1, 1'b1, 1'b0, 8'h00}
                                     : fci_cyc_t'{1'b1, 1'b0, 1'b0, CMD_READ_STATUS};
            OP_CLEAR_STATUS: c = idx ? '0 : fci_cyc_t'{1'b1, 1'b0, 1'b0, CMD_CLEAR_STATUS};
            OP_ERASE:        c = idx ? fci_cyc_t'{1'b1, 1'b0, 1'b0, CMD_CONFIRM}
                                     : fci_cyc_t'{1'b1, 1'b0, 1'b0, CMD_ERASE_SETUP};
            OP_PROGRAM:      c = idx ? fci_cyc_t'{1'b1, 1'b0, 1'b1, 8'h00}
                                     : fci_cyc_t'{1'b1, 1'b0, 1'b0, CMD_PROG_SETUP};
            OP_PROGRAM_ALT:  c = idx ? fci_cyc_t'{1'b1, 1'b0, 1'b1, 8'h00}
                                     : fci_cyc_t'{1'b1, 1'b0, 1'b0, CMD_PROG_ALT};
            OP_SUSPEND:      c = idx ? '0 : fci_cyc_t'{1'b1, 1'b0, 1'b0, CMD_SUSPEND};
            OP_RESUME:       c = idx ? '0 : fci_cyc_t'{1'b1, 1'b0, 1'b0, CMD_CONFIRM};
            OP_READ:         c = idx ? '0 : fci_cyc_t'{1'b1, 1'b1, 1'b0, 8'h00};
            default:         c = '0;
        endcase
        return c;
    endfunction : op_step

    // only defined codes ever reach the flash
    function automatic logic op_known(input logic [3:0] op);
        fci_cyc_t c;
        c = op_step(op, 1'b0);
        return c.valid;
    endfunction : op_known

    fci_state_t         state_q;
    logic [7:0]         cnt_q;
    logic               idx_q;
    logic [3:0]         op_q;
    logic [ADDR_W-1:0]  addr_q;
    logic [DATA_W-1:0]  wdata_q;
    logic [DATA_W-1:0]  rdata_q;
    logic [2:0]         pinctl_q;
    logic               op_err_q;
    logic               done_q;
    logic [DATA_W-1:0]  dq_s1_q;
    logic [DATA_W-1:0]  dq_s2_q;
    logic               rb_s1_q;
    logic               rb_s2_q;
    fci_cyc_t           cyc;
    fci_cyc_t           nxt;
    logic               acc;
    logic               wr_ctrl;
    logic               busy;
    logic               seq_end;
    logic               mapped;

    assign cyc     = op_step(op_q, idx_q);
    assign nxt     = op_step(op_q, 1'b1);
    assign busy    = (state_q != S_IDLE);
    assign acc     = psel & penable & pready;
    assign mapped  = (paddr == REG_CTRL) | (paddr == REG_ADDR) | (paddr == REG_WDATA)
                   | (paddr == REG_STATUS) | (paddr == REG_RDATA) | (paddr == REG_PINS);
    // refusal is decided at setup; busy may fall before the access edge, so honour the answer given
    assign wr_ctrl = acc & pwrite & (paddr == REG_CTRL) & ~pslverr & ~busy;
    assign seq_end = (state_q == S_RECOVER) && (cnt_q == 8'h00) && (idx_q || !nxt.valid);

    // pin inputs are asynchronous: two flops before anything reads them
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
            rb_s1_q <= 1'b0;
            rb_s2_q <= 1'b0;
        end
        else
        begin
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
            rb_s1_q <= ready_busy_in;
            rb_s2_q <= rb_s1_q;
        end
    end

    // apb slave: pready rises one cycle after setup, no extra waits
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & (~mapped | (pwrite & (paddr == REG_CTRL) & busy));
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    REG_CTRL:   prdata <= {28'h0000000, op_q};
                    REG_ADDR:   prdata <= {12'h000, addr_q};
                    REG_WDATA:  prdata <= {16'h0000, wdata_q};
                    REG_STATUS: prdata <= {28'h0000000, done_q, op_err_q, rb_s2_q, busy};
                    REG_RDATA:  prdata <= {16'h0000, rdata_q};
                    REG_PINS:   prdata <= {29'h00000000, pinctl_q};
                    default:    prdata <= '0;
                endcase
            end
        end
    end

    // software-written configuration; address and data frozen while busy
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_q   <= '0;
            wdata_q  <= '0;
            pinctl_q <= PINS_RESET;
        end
        else if (acc && pwrite && !busy)
        begin
            if (paddr == REG_ADDR)
                addr_q <= pwdata[ADDR_W-1:0];
            if (paddr == REG_WDATA)
                wdata_q <= pwdata[DATA_W-1:0];
            if (paddr == REG_PINS)
                pinctl_q <= pwdata[2:0];
        end
    end

    // sticky flags: hardware set wins over a same-cycle write-one clear
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            op_err_q <= 1'b0;
            done_q   <= 1'b0;
        end
        else
        begin
            if (wr_ctrl && !op_known(pwdata[3:0]))
                op_err_q <= 1'b1;
            else if (acc && pwrite && paddr == REG_STATUS && pwdata[ST_OP_ERR])
                op_err_q <= 1'b0;
            if (seq_end)
                done_q <= 1'b1;
            else if (acc && pwrite && paddr == REG_STATUS && pwdata[ST_DONE])
                done_q <= 1'b0;
        end
    end

    // bus cycle sequencer
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= S_IDLE;
            cnt_q   <= '0;
            idx_q   <= 1'b0;
            op_q    <= OP_READ_ARRAY;
            rdata_q <= '0;
        end
        else
        begin
            case (state_q)
                S_IDLE:
                begin
                    if (wr_ctrl && op_known(pwdata[3:0]))
                    begin
                        op_q    <= pwdata[3:0];
                        idx_q   <= 1'b0;
                        cnt_q   <= 8'(T_SETUP_CYC - 1);
                        state_q <= S_SETUP;
                    end
                end
                S_SETUP:
                begin
                    if (cnt_q == 8'h00)
                    begin
                        cnt_q   <= cyc.rd ? 8'(T_ACCESS_CYC - 1) : 8'(T_STROBE_CYC - 1);
                        state_q <= S_STROBE;
                    end
                    else
                        cnt_q <= cnt_q - 8'h01;
                end
                S_STROBE:
                begin
                    if (cnt_q == 8'h00)
                    begin
                        if (cyc.rd)
                            rdata_q <= dq_s2_q;
                        cnt_q   <= 8'(T_RECOVER_CYC - 1);
                        state_q <= S_RECOVER;
                    end
                    else
                        cnt_q <= cnt_q - 8'h01;
                end
                S_RECOVER:
                begin
                    if (cnt_q != 8'h00)
                        cnt_q <= cnt_q - 8'h01;
                    else if (seq_end)
                        state_q <= S_IDLE;
                    else
                    begin
                        idx_q   <= 1'b1;
                        cnt_q   <= 8'(T_SETUP_CYC - 1);
                        state_q <= S_SETUP;
                    end
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end

    // pin drivers; enables go high in recovery so status relatches next read
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            pins <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, '0, '0, 1'b0};
        else
        begin
            pins.write_protect_n    <= pinctl_q[PIN_WP];
            pins.reset_powerdown_n  <= pinctl_q[PIN_RP];
            pins.rp_high_voltage_en <= pinctl_q[PIN_RP_HV];
            pins.addr               <= addr_q;
            pins.ce_n               <= !(state_q == S_SETUP || state_q == S_STROBE);
            pins.oe_n               <= !(state_q == S_STROBE && cyc.rd);
            pins.we_n               <= !(state_q == S_STROBE && !cyc.rd);
            pins.dq_oe              <= (state_q == S_SETUP || state_q == S_STROBE) && !cyc.rd;
            pins.dq_out             <= cyc.use_wdata ? wdata_q : {8'h00, cyc.code};
        end
    end

endmodule : fci_host_ctrl

/* File: fci_host_ctrl_props.sv */
/*
 * Checker for the host controller: flash strobe shapes and APB answers.
 * Assumes it is bound onto fci_host_ctrl and sees only its ports.
 */
`timescale 1ns/1ps
module fci_host_ctrl_props
    import fci_pkg::*;
(
    input wire logic              clock,
    input wire logic              rst_b,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [31:0]       prdata,
    input wire fci_pins_t         pins,
    input wire logic [DATA_W-1:0] dq_in,
    input wire logic              ready_busy_in
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    sequence s_setup;
        (pins.oe_n && pins.we_n && !pins.ce_n) [*2];
    endsequence
    sequence s_wr_pulse;
        (!pins.we_n && pins.dq_oe) [*6] ##1 pins.we_n;
    endsequence

    a_strobe_excl: assert property (pins.oe_n || pins.we_n)
        else $error("output and write enable low together");
    a_setup_first: assert property ($fell(pins.ce_n) |-> s_setup)
        else $error("strobe began without two setup cycles");
    a_write_pulse: assert property ($fell(pins.we_n) |-> s_wr_pulse)
        else $error("write pulse shape wrong");
    a_data_held: assert property ($rose(pins.we_n) |-> $stable(pins.dq_out) && $stable(pins.addr))
        else $error("data or address moved at write rise");
    a_oe_recover: assert property ($rose(pins.oe_n) |-> pins.oe_n [*3])
        else $error("output enable not held high between reads");
    a_read_undriven: assert property (!pins.oe_n |-> !pins.dq_oe && !pins.ce_n)
        else $error("data driven during read");
    a_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");
    a_err_unmapped: assert property (psel && !penable && !pwrite && paddr > REG_PINS |=> pslverr && prdata == 0)
        else $error("unmapped read not refused");
endmodule : fci_host_ctrl_props

/* File: fci_flash_model.sv */
/*
 * Behavioural model of the boot-block flash on the controller's pins.
 * Assumes the bench resolves the data lines and pulls ready/busy high.
 */
`timescale 1ns/1ps
module fci_flash_model
    import fci_pkg::*;
#(
    parameter int          ERASE_NS    = 4000,
    parameter int          PROG_NS     = 50,
    parameter logic [15:0] MAKER_CODE  = 16'h00a5, // arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h003c, // arbitrary value
    parameter logic [7:0]  BOOT_FIRST  = 8'hfe
)
(
    input  wire fci_pins_t         pins,
    input  wire logic              supply_ok,
    output logic [DATA_W-1:0]      dq,
    output logic                   rb_low
);
    logic [15:0] mem [int];
    logic [7:0]  sr = 8'h80;
    logic [7:0]  srl = 8'h80;
    logic [1:0]  mode = 0;
    logic [1:0]  pend = 0;
    logic        busy = 0;
    logic        susp = 0;
    logic        op_er = 0;
    logic [19:0] op_a = 0;
    logic [15:0] op_d = 0;
    logic [15:0] last = 0;
    logic [15:0] rdv = 0;
    event        kick;
    wire         wr_n = pins.ce_n | pins.we_n;
    wire         rd_n = pins.ce_n | pins.oe_n;

    always @(posedge pins.reset_powerdown_n) mode = 0;

    task automatic start(input logic er, input logic [19:0] a, input logic [15:0] d);
        mode = 2;
        if (!supply_ok) sr |= er ? 8'h28 : 8'h18;
        else if (a[19:12] >= BOOT_FIRST && !pins.write_protect_n && !pins.rp_high_voltage_en)
            sr |= er ? 8'h22 : 8'h12;
        else
        begin
            op_er = er; op_a = a; op_d = d; busy = 1; sr[7] = 0;
            ->kick;
        end
    endtask : start

    always @(posedge wr_n)
    begin : cmd
        logic [7:0] c;
        c = pins.dq_out[7:0];
        if (pend == 1)
        begin
            pend = 0; mode = 2;
            if (c == CMD_CONFIRM) start(1, pins.addr, 0);
            else sr |= 8'h30;
        end
        else if (pend == 2)
        begin
            pend = 0; start(0, pins.addr, pins.dq_out);
        end
        else case (c)
            CMD_READ_ARRAY: if (!busy || susp) mode = 0;
            CMD_READ_ID: mode = 1;
            CMD_READ_STATUS: mode = 2;
            CMD_CLEAR_STATUS: if (!susp) sr &= 8'hc5;
            CMD_ERASE_SETUP: pend = 1;
            CMD_PROG_SETUP, CMD_PROG_ALT: pend = 2;
            CMD_SUSPEND: if (busy) begin susp = 1; sr[7] = 1; sr[6] = op_er; sr[2] = !op_er; mode = 2; end
            CMD_CONFIRM: if (susp) begin susp = 0; sr[7] = 0; sr[6] = 0; sr[2] = 0; mode = 2; end
            default: ;
        endcase
    end

    always
    begin : engine
        int left;
        @kick;
        left = op_er ? ERASE_NS : PROG_NS;
        while (left > 0) begin #10; if (!susp) left -= 10; end
        if (op_er) for (int i = 0; i < 4096; i++) mem[{op_a[19:12], i[11:0]}] = 16'hffff;
        else mem[op_a] = op_d;
        busy = 0; sr[7] = 1;
    end

    always @(negedge rd_n) srl = sr;
    always @(posedge rd_n) last = rdv;

    // a released bus shows the inverse of its last value, never a stale copy
    always @(rd_n, mode, pins, srl, last, busy)
    begin
        if (mode == 0) rdv = mem.exists(pins.addr) ? mem[pins.addr] : 16'hffff;
        else if (mode == 1) rdv = pins.addr == 0 ? MAKER_CODE : pins.addr == 1 ? DEVICE_CODE : 16'h0000;
        else rdv = {8'h00, srl};
        dq = rd_n ? ~last : rdv;
    end

    assign rb_low = busy && !susp;
endmodule : fci_flash_model

/* File: fci_host_ctrl_bench.sv */
/*
 * Self-checking bench: APB master, flash model, table of plain cases.
 * Assumes the checker file and flash model are compiled before it.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module fci_host_ctrl_bench
    import fci_pkg::*;
;
    localparam logic [15:0] MAKER  = 16'h00a5; // arbitrary value
    localparam logic [15:0] DEVICE = 16'h003c; // arbitrary value
    typedef struct packed { logic [3:0] op; logic [19:0] a; logic [15:0] d; logic [15:0] exp; } fci_row_t;
    fci_row_t    rows [10] = '{
        '{OP_PROGRAM, 20'h01234, 16'h5a5a, 16'h0080}, '{OP_READ_ARRAY, 20'h01234, 16'h0, 16'h5a5a},
        '{OP_PROGRAM_ALT, 20'h04000, 16'h1234, 16'h0080}, '{OP_READ_ARRAY, 20'h04000, 16'h0, 16'h1234},
        '{OP_READ_ID, 20'h0, 16'h0, MAKER}, '{OP_READ_ID, 20'h1, 16'h0, DEVICE},
        '{OP_READ_STATUS, 20'h0, 16'h0, 16'h0080}, '{OP_ERASE, 20'h01000, 16'h0, 16'h0080},
        '{OP_READ_ARRAY, 20'h01234, 16'h0, 16'hffff}, '{OP_READ_ARRAY, 20'h04000, 16'h0, 16'h1234}};
    logic        clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, supply_ok = 1, serr;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [15:0] fdq;
    logic        rb_low;
    int          mismatches = 0, checks_done = 0;
    wire logic   pready, pslverr;
    wire logic [31:0] prdata;
    wire fci_pins_t   pins;
    wire logic [15:0] dq_line = pins.dq_oe ? pins.dq_out : fdq;
    wire logic        rb_line = !rb_low;

    fci_host_ctrl i_dut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .pins(pins),
        .dq_in(dq_line), .ready_busy_in(rb_line));
    fci_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) i_flash (.pins(pins),
        .supply_ok(supply_ok), .dq(fdq), .rb_low(rb_low));

    initial forever #5 clock = ~clock;

    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    task timeout;
        mismatches++;
        $display("wait limit ran out at %0t", $time);
        end_of_test();
    endtask : timeout
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        n = 0;
        do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata; serr = pslverr;
        psel <= 0; penable <= 0;
        if (pready !== 1'b1) timeout();
    endtask : apb
    task automatic op(input logic [3:0] o, input logic [19:0] a, input logic [15:0] d);
        int n;
        apb(1, REG_ADDR, {12'h0, a});
        apb(1, REG_WDATA, {16'h0, d});
        apb(1, REG_CTRL, {28'h0, o});
        n = 0;
        do begin apb(0, REG_STATUS, 0); n++; end while (rd[ST_BUSY] !== 1'b0 && n < 50);
        if (rd[ST_BUSY] !== 1'b0) timeout();
    endtask : op
    task automatic fread(input logic [19:0] a);
        op(OP_READ, a, 0);
        apb(0, REG_RDATA, 0);
    endtask : fread
    task automatic settle;
        int n;
        n = 0;
        while (rb_line !== 1'b1 && n < 1000) begin @(posedge clock); n++; end
        if (rb_line !== 1'b1) timeout();
    endtask : settle

    initial
    begin
        repeat (12) @(posedge clock);
        `CHK({pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe, pins.write_protect_n}, 5'b11100);
        rst_b <= 1;
        apb(0, REG_PINS, 0); `CHK(rd, 32'h2);
        apb(0, 8'h40, 0); `CHK({serr, rd}, 33'h1_0000_0000);
        fread(0); `CHK(rd[15:0], 16'hffff);
        // done and ready set, no error, idle; then both sticky flags cleared by writing one
        apb(0, REG_STATUS, 0); `CHK(rd[3:0], 4'ha);
        apb(1, REG_STATUS, 32'h8); apb(0, REG_STATUS, 0); `CHK(rd[ST_DONE], 1'b0);
        apb(1, REG_CTRL, 32'hf); apb(0, REG_STATUS, 0); `CHK(rd[3:0], 4'h6);
        apb(1, REG_STATUS, 32'h4); apb(0, REG_STATUS, 0); `CHK(rd[ST_OP_ERR], 1'b0);
        foreach (rows[i])
        begin
            op(rows[i].op, rows[i].a, rows[i].d);
            settle();
            fread(rows[i].a); `CHK(rd[15:0], rows[i].exp);
        end
        // supply below lockout: both operations refused, errors pile up
        supply_ok <= 0;
        op(OP_PROGRAM, 20'h01234, 16'h0000); fread(0); `CHK(rd[15:0], 16'h0098);
        op(OP_ERASE, 20'h04000, 0); fread(0); `CHK(rd[15:0], 16'h00b8);
        op(OP_READ_ARRAY, 0, 0); fread(20'h01234); `CHK(rd[15:0], 16'hffff);
        fread(20'h04000); `CHK(rd[15:0], 16'h1234);
        supply_ok <= 1;
        op(OP_ERASE, 20'h03000, 0);
        op(OP_READ_ARRAY, 0, 0); fread(20'h04000); `CHK(rd[15:0], 16'h0038);
        op(OP_SUSPEND, 0, 0); fread(0); `CHK(rd[15:0], 16'h00f8);
        apb(0, REG_STATUS, 0); `CHK(rd[ST_RB_READY], 1'b1);
        op(OP_CLEAR_STATUS, 0, 0); op(OP_READ_STATUS, 0, 0);
        apb(0, REG_RDATA, 0); `CHK(rd[15:0], 16'h00f8);
        op(OP_READ_ARRAY, 0, 0); fread(20'h04000); `CHK(rd[15:0], 16'h1234);
        op(OP_RESUME, 0, 0); fread(0); `CHK(rd[15:0], 16'h0038);
        apb(0, REG_STATUS, 0); `CHK(rd[ST_RB_READY], 1'b0);
        settle(); fread(0); `CHK(rd[15:0], 16'h00b8);
        op(OP_CLEAR_STATUS, 0, 0); op(OP_ERASE, 20'hff000, 0);
        fread(0); `CHK(rd[15:0], 16'h00a2);
        op(OP_CLEAR_STATUS, 0, 0); apb(1, REG_PINS, 32'h3);
        op(OP_PROGRAM, 20'hff010, 16'h0f0f); settle();
        op(OP_READ_ARRAY, 0, 0); fread(20'hff010); `CHK(rd[15:0], 16'h0f0f);
        // a command written while a sequence runs is refused and never reaches the flash
        apb(1, REG_CTRL, {28'h0, OP_READ_STATUS});
        apb(1, REG_CTRL, {28'h0, OP_READ_ARRAY}); `CHK(serr, 1'b1);
        fread(20'hff010); fread(20'hff010); `CHK(rd[15:0], 16'h0080);
        end_of_test();
    end
endmodule : fci_host_ctrl_bench

bind fci_host_ctrl fci_host_ctrl_props i_props (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .pins(pins), .dq_in(dq_in), .ready_busy_in(ready_busy_in));
